// ---- hw/pesc_pkg.sv ----
// constants and types for the error severity and correctable status bank
package pesc_pkg;
   // ==========================================================
   // types
   typedef logic [31:0] pesc_word_t;
   typedef logic [11:0] pesc_addr_t;

   // ==========================================================
   // register offsets
   localparam pesc_addr_t UNC_MASK_OFS = 12'h108;
   localparam pesc_addr_t UNC_SEV_OFS = 12'h10C;
   localparam pesc_addr_t COR_STAT_OFS = 12'h110;
   localparam pesc_addr_t COR_MASK_OFS = 12'h114;
   localparam pesc_addr_t INT_STAT_OFS = 12'h200;
   localparam pesc_addr_t INT_MASK_OFS = 12'h204;

   // ==========================================================
   // uncorrectable error bit positions
   localparam int UNC_TRAIN_BIT = 0;
   localparam int UNC_DLP_BIT = 4;
   localparam int UNC_SDOWN_BIT = 5;
   localparam int UNC_POISON_BIT = 12;
   localparam int UNC_FCP_BIT = 13;
   localparam int UNC_RXOVF_BIT = 17;
   localparam int UNC_MALF_BIT = 18;
   localparam int UNC_ECRC_BIT = 19;
   localparam int UNC_UR_BIT = 20;
   localparam int UNC_ACS_BIT = 21;

   // ==========================================================
   // correctable error bit positions
   localparam int COR_RXERR_BIT = 0;
   localparam int COR_BADTLP_BIT = 6;
   localparam int COR_BADDLLP_BIT = 7;
   localparam int COR_RPLROLL_BIT = 8;
   localparam int COR_RPLTMO_BIT = 12;
   localparam int COR_ADVNF_BIT = 13;

   // ==========================================================
   // interrupt status bit positions
   localparam int INT_COR_BIT = 0;
   localparam int INT_NFE_BIT = 1;
   localparam int INT_FE_BIT = 2;

   // ==========================================================
   // implemented bits and values after reset
   localparam pesc_word_t UNC_IMPL = 32'h003FF031;
   localparam pesc_word_t UNC_SEV_RST = 32'h00062031;
   localparam pesc_word_t UNC_MASK_RST = 32'h00000000;
   localparam pesc_word_t COR_IMPL = 32'h000031C1;
   localparam pesc_word_t COR_STAT_RST = 32'h00000000;
   localparam pesc_word_t COR_MASK_RST = 32'h00002000;
   localparam pesc_word_t INT_IMPL = 32'h00000007;
   localparam pesc_word_t INT_STAT_RST = 32'h00000000;
   localparam pesc_word_t INT_MASK_RST = 32'h00000000;
   localparam pesc_word_t WORD_ZERO = 32'h00000000;
endpackage : pesc_pkg

// ---- hw/pesc_w1c_bank.sv ----
// sticky flag word, set by events and cleared by writing one
`timescale 1ns/100ps
`default_nettype none
module pesc_w1c_bank (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire pesc_pkg::pesc_word_t i_impl,
   input wire pesc_pkg::pesc_word_t i_rst_val,
   input wire pesc_pkg::pesc_word_t i_set,
   input wire logic i_clr_wr,
   input wire pesc_pkg::pesc_word_t i_wdata,
   output var pesc_pkg::pesc_word_t o_flags
);
   import pesc_pkg::*;

   pesc_word_t flags_reg;
   pesc_word_t flags_next;
   pesc_word_t clr_bits;

   // ==========================================================
   // set wins over a clear in the same cycle
   always_comb begin
      clr_bits = i_clr_wr ? i_wdata : WORD_ZERO;
      flags_next = ((flags_reg & ~clr_bits) | i_set) & i_impl;
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         flags_reg <= i_rst_val;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign o_flags = flags_reg;
endmodule : pesc_w1c_bank
`default_nettype wire

// ---- hw/pesc_top.sv ----
// error severity, correctable status and error message generation
// Summary of operation
// RULE1 - severity bits writable, sticky; one means fatal
// RULE2 - receiver overflow, malformed severities reset fatal
// RULE3 - end-to-end CRC severity resets non-fatal
// RULE4 - unsupported request, access violation reset non-fatal
// RULE5 - surprise down severity downstream only, resets fatal
// RULE6 - bit 0 receiver error, sticky, write-one clear
// RULE7 - bit 6 bad packet, reset zero, W1C
// RULE8 - bit 7 bad link packet, reset zero, W1C
// RULE9 - bit 8 replay count rollover, W1C
// RULE10 - bit 12 replay timer expiry, W1C
// RULE11 - bit 13 advisory non-fatal error, W1C
// RULE12 - masked errors send no message, no log
// RULE13 - reserved bits read zero, ignore writes
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pesc_top (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_hot_rst,
   input wire logic i_port_dsp,
   input wire pesc_pkg::pesc_addr_t i_addr,
   input wire pesc_pkg::pesc_word_t i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output var pesc_pkg::pesc_word_t o_rdata,
   input wire pesc_pkg::pesc_word_t i_unc_evt,
   input wire pesc_pkg::pesc_word_t i_cor_evt,
   output var logic o_msg_cor,
   output var logic o_msg_nonfatal,
   output var logic o_msg_fatal,
   output var logic o_log_req,
   output var logic o_irq
);
   import pesc_pkg::*;

   // ==========================================================
   // declarations
   pesc_word_t unc_sev_reg;
   pesc_word_t unc_mask_reg;
   pesc_word_t cor_mask_reg;
   pesc_word_t int_mask_reg;
   pesc_word_t cor_stat;
   pesc_word_t int_stat;
   pesc_word_t rdata_reg;
   pesc_word_t rdata_next;
   pesc_word_t unc_new;
   pesc_word_t unc_live;
   pesc_word_t sev_eff;
   pesc_word_t cor_new;
   pesc_word_t int_set;
   logic dsp_s1;
   logic dsp_s2;
   logic dsp_s3;
   logic port_dsp_reg;
   logic msg_cor_reg;
   logic msg_cor_next;
   logic msg_nf_reg;
   logic msg_nf_next;
   logic msg_fe_reg;
   logic msg_fe_next;
   logic log_req_reg;
   logic log_req_next;
   logic irq_reg;
   logic irq_next;
   logic int_rst;
   logic cor_clr_wr;
   logic int_clr_wr;

   // ==========================================================
   // register decode
   function automatic logic wr_hit(input pesc_addr_t ofs);
      return i_wr && (i_addr == ofs);
   endfunction : wr_hit

   function automatic logic any_bit(input pesc_word_t w);
      return |w;
   endfunction : any_bit

   // ==========================================================
   // port type strap, three stage sync
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         dsp_s1 <= 1'b0;
         dsp_s2 <= 1'b0;
         dsp_s3 <= 1'b0;
      end else begin
         dsp_s1 <= i_port_dsp;
         dsp_s2 <= dsp_s1;
         dsp_s3 <= dsp_s2;
      end
   end

   // accept a change once stages two and three agree
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         port_dsp_reg <= 1'b0;
      end else if (dsp_s2 == dsp_s3) begin
         port_dsp_reg <= dsp_s2;
      end
   end

   // ==========================================================
   // sticky severity and mask registers, kept over hot reset
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         unc_sev_reg <= UNC_SEV_RST; // see RULE2 see RULE3 see RULE4 see RULE5
      end else if (wr_hit(UNC_SEV_OFS)) begin
         unc_sev_reg <= i_wdata & UNC_IMPL; // see RULE1 see RULE13
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         unc_mask_reg <= UNC_MASK_RST;
      end else if (wr_hit(UNC_MASK_OFS)) begin
         unc_mask_reg <= i_wdata & UNC_IMPL; // see RULE13
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         cor_mask_reg <= COR_MASK_RST;
      end else if (wr_hit(COR_MASK_OFS)) begin
         cor_mask_reg <= i_wdata & COR_IMPL; // see RULE13
      end
   end

   // ==========================================================
   // correctable status flags
   assign cor_new = i_cor_evt & COR_IMPL;
   // clear strobes decoded from the live bus pins
   assign cor_clr_wr = i_wr && (i_addr == COR_STAT_OFS);

   pesc_w1c_bank u_cor_stat (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_impl(COR_IMPL),
      .i_rst_val(COR_STAT_RST),
      .i_set(cor_new), // see RULE6 see RULE7 see RULE8 see RULE9 see RULE10 see RULE11
      .i_clr_wr(cor_clr_wr),
      .i_wdata(i_wdata),
      .o_flags(cor_stat)
   );

   // ==========================================================
   // error classification and messages
   always_comb begin
      unc_new = i_unc_evt & UNC_IMPL;
      sev_eff = unc_sev_reg;
      // surprise down exists only on a downstream port
      if (!port_dsp_reg) begin
         unc_new[UNC_SDOWN_BIT] = 1'b0; // see RULE5
         sev_eff[UNC_SDOWN_BIT] = 1'b0; // see RULE5
      end
      unc_live = unc_new & ~unc_mask_reg; // see RULE12
      msg_fe_next = any_bit(unc_live & sev_eff); // see RULE1
      msg_nf_next = any_bit(unc_live & ~sev_eff); // see RULE1
      log_req_next = any_bit(unc_live); // see RULE12
      msg_cor_next = any_bit(cor_new & ~cor_mask_reg); // see RULE12
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst || i_hot_rst) begin
         msg_fe_reg <= 1'b0;
         msg_nf_reg <= 1'b0;
         msg_cor_reg <= 1'b0;
         log_req_reg <= 1'b0;
      end else begin
         msg_fe_reg <= msg_fe_next;
         msg_nf_reg <= msg_nf_next;
         msg_cor_reg <= msg_cor_next;
         log_req_reg <= log_req_next;
      end
   end

   // ==========================================================
   // interrupt flags and mask, cleared by hot reset too
   assign int_rst = i_srst | i_hot_rst;
   assign int_clr_wr = i_wr && (i_addr == INT_STAT_OFS);

   always_comb begin
      int_set = WORD_ZERO;
      int_set[INT_COR_BIT] = msg_cor_next;
      int_set[INT_NFE_BIT] = msg_nf_next;
      int_set[INT_FE_BIT] = msg_fe_next;
   end

   pesc_w1c_bank u_int_stat (
      .i_mclk(i_mclk),
      .i_srst(int_rst),
      .i_impl(INT_IMPL),
      .i_rst_val(INT_STAT_RST),
      .i_set(int_set),
      .i_clr_wr(int_clr_wr),
      .i_wdata(i_wdata),
      .o_flags(int_stat)
   );

   always_ff @(posedge i_mclk) begin
      if (int_rst) begin
         int_mask_reg <= INT_MASK_RST;
      end else if (wr_hit(INT_MASK_OFS)) begin
         int_mask_reg <= i_wdata & INT_IMPL;
      end
   end

   assign irq_next = any_bit(int_stat & ~int_mask_reg);

   always_ff @(posedge i_mclk) begin
      if (int_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // ==========================================================
   // read path, data one cycle after the strobe
   always_comb begin
      rdata_next = WORD_ZERO;
      if (i_rd) begin
         case (i_addr)
            UNC_MASK_OFS: rdata_next = unc_mask_reg;
            UNC_SEV_OFS: rdata_next = unc_sev_reg & UNC_IMPL; // see RULE13
            COR_STAT_OFS: rdata_next = cor_stat & COR_IMPL; // see RULE13
            COR_MASK_OFS: rdata_next = cor_mask_reg;
            INT_STAT_OFS: rdata_next = int_stat;
            INT_MASK_OFS: rdata_next = int_mask_reg;
            default: rdata_next = WORD_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rdata_reg <= WORD_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // outputs
   assign o_rdata = rdata_reg;
   assign o_msg_cor = msg_cor_reg;
   assign o_msg_nonfatal = msg_nf_reg;
   assign o_msg_fatal = msg_fe_reg;
   assign o_log_req = log_req_reg;
   assign o_irq = irq_reg;

   // ==========================================================
   // checks
   AST_SEV_RESET: assert property (@(posedge i_mclk) // see RULE2 see RULE3 see RULE4 see RULE5
      i_srst |=> (unc_sev_reg[UNC_RXOVF_BIT] && unc_sev_reg[UNC_MALF_BIT]
                  && !unc_sev_reg[UNC_ECRC_BIT] && !unc_sev_reg[UNC_UR_BIT]
                  && !unc_sev_reg[UNC_ACS_BIT] && unc_sev_reg[UNC_SDOWN_BIT]))
      else $error("severity reset value wrong");

   AST_SEV_WRITE_READ: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE1 see RULE13
      (i_wr && i_addr == UNC_SEV_OFS) ##1 (i_rd && i_addr == UNC_SEV_OFS && !i_wr)
      |=> o_rdata == ($past(i_wdata, 2) & UNC_IMPL))
      else $error("severity readback differs from write");

   AST_SEV_STICKY: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE1
      (i_hot_rst && !(i_wr && i_addr == UNC_SEV_OFS)) |=> $stable(unc_sev_reg))
      else $error("severity changed by hot reset");

   AST_RSVD_ZERO: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE13
      ((unc_sev_reg & ~UNC_IMPL) == WORD_ZERO) && ((cor_stat & ~COR_IMPL) == WORD_ZERO))
      else $error("reserved bit set");

   AST_COR_RXERR: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE6
      i_cor_evt[COR_RXERR_BIT] |=> cor_stat[COR_RXERR_BIT] [*2] or (cor_stat[COR_RXERR_BIT] ##1 $past(i_wr)))
      else $error("receiver error flag not kept");

   AST_COR_SET: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE7 see RULE8 see RULE9 see RULE10 see RULE11
      (cor_new != WORD_ZERO) |=> ((cor_stat & $past(cor_new)) == $past(cor_new)))
      else $error("correctable flag not set by event");

   AST_COR_CLEAR: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE6 see RULE7
      (i_wr && i_addr == COR_STAT_OFS && cor_new == WORD_ZERO)
      |=> ((cor_stat & $past(i_wdata)) == WORD_ZERO))
      else $error("write one did not clear");

   AST_MASKED_SILENT: assert property (@(posedge i_mclk) disable iff (i_srst || i_hot_rst) // see RULE12
      ((cor_new & ~cor_mask_reg) == WORD_ZERO) && ((unc_new & ~unc_mask_reg) == WORD_ZERO)
      |=> !o_msg_cor && !o_msg_fatal && !o_msg_nonfatal && !o_log_req)
      else $error("masked error produced message");

   AST_FATAL_MSG: assert property (@(posedge i_mclk) disable iff (i_srst || i_hot_rst) // see RULE1
      any_bit(unc_live & unc_sev_reg & ~(32'h1 << UNC_SDOWN_BIT)) |=> o_msg_fatal && o_log_req)
      else $error("fatal error gave no fatal message");

   AST_SDOWN_UPSTREAM: assert property (@(posedge i_mclk) disable iff (i_srst || i_hot_rst) // see RULE5
      (!port_dsp_reg && (i_unc_evt & UNC_IMPL) == (32'h1 << UNC_SDOWN_BIT) && cor_new == WORD_ZERO)
      |=> !o_msg_fatal && !o_msg_nonfatal)
      else $error("surprise down reported on upstream port");

   AST_IRQ_LEVEL: assert property (@(posedge i_mclk) disable iff (int_rst)
      (msg_fe_next && !int_mask_reg[INT_FE_BIT] && !(i_wr && i_addr == INT_MASK_OFS)) |-> ##2 o_irq)
      else $error("interrupt not raised");

   AST_NF_MSG: assert property (@(posedge i_mclk) disable iff (i_srst || i_hot_rst) // see RULE1
      any_bit(unc_live & ~sev_eff) |=> o_msg_nonfatal && o_log_req)
      else $error("non-fatal error gave no non-fatal message");

   AST_COR_MSG: assert property (@(posedge i_mclk) disable iff (i_srst || i_hot_rst) // see RULE12
      any_bit(cor_new & ~cor_mask_reg) |=> o_msg_cor)
      else $error("unmasked correctable error gave no message");

   AST_COR_NO_LOG: assert property (@(posedge i_mclk) disable iff (i_srst || i_hot_rst) // see RULE12
      !any_bit(unc_live) |=> !o_log_req)
      else $error("log request without unmasked uncorrectable error");

   AST_SEV_HOLD: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE1
      !(i_wr && i_addr == UNC_SEV_OFS) |=> $stable(unc_sev_reg))
      else $error("severity changed without a write");

   AST_COR_KEPT: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE6
      !cor_clr_wr |=> ((cor_stat & $past(cor_stat)) == $past(cor_stat)))
      else $error("correctable flag lost without a clear");

   AST_UNMAPPED_READ: assert property (@(posedge i_mclk) disable iff (i_srst) // see RULE13
      (i_rd && i_addr != UNC_MASK_OFS && i_addr != UNC_SEV_OFS && i_addr != COR_STAT_OFS
       && i_addr != COR_MASK_OFS && i_addr != INT_STAT_OFS && i_addr != INT_MASK_OFS)
      |=> o_rdata == WORD_ZERO)
      else $error("unmapped read not zero");

   AST_RDATA_IDLE: assert property (@(posedge i_mclk) disable iff (i_srst)
      !i_rd |=> o_rdata == WORD_ZERO)
      else $error("read data outside its cycle");

   AST_HOT_RST_QUIET: assert property (@(posedge i_mclk) disable iff (i_srst)
      i_hot_rst |=> !o_msg_cor && !o_msg_fatal && !o_msg_nonfatal && !o_log_req && !o_irq)
      else $error("outputs active after hot reset");

   AST_IRQ_MASKED: assert property (@(posedge i_mclk) disable iff (int_rst)
      ((int_stat & ~int_mask_reg) == WORD_ZERO) |=> !o_irq)
      else $error("interrupt without unmasked status");
endmodule : pesc_top
`default_nettype wire

// ---- verif/pesc_rc_model.sv ----
// root complex model counting error messages and log requests
`timescale 1ns/100ps
`default_nettype none
module pesc_rc_model (
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic i_msg_cor,
   input wire logic i_msg_nonfatal,
   input wire logic i_msg_fatal,
   input wire logic i_log_req,
   output var pesc_pkg::pesc_word_t o_n_cor,
   output var pesc_pkg::pesc_word_t o_n_nf,
   output var pesc_pkg::pesc_word_t o_n_fat,
   output var pesc_pkg::pesc_word_t o_n_log
);
   import pesc_pkg::*;
   // ==========================================================
   // one count per cycle that a message stands
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_n_cor <= WORD_ZERO;
         o_n_nf <= WORD_ZERO;
         o_n_fat <= WORD_ZERO;
         o_n_log <= WORD_ZERO;
      end else begin
         o_n_cor <= o_n_cor + {31'h0, i_msg_cor};
         o_n_nf <= o_n_nf + {31'h0, i_msg_nonfatal};
         o_n_fat <= o_n_fat + {31'h0, i_msg_fatal};
         o_n_log <= o_n_log + {31'h0, i_log_req};
      end
   end
endmodule : pesc_rc_model
`default_nettype wire

// ---- verif/pesc_top_test.sv ----
// self-checking bench for the severity and correctable status bank
`timescale 1ns/100ps
`default_nettype none
module pesc_top_test;
   import pesc_pkg::*;
   typedef struct packed {pesc_word_t evt; logic msg;} pesc_row_s;
   logic i_mclk = 1'b0;
   logic i_srst = 1'b1;
   logic i_hot_rst = 1'b0;
   logic i_port_dsp = 1'b0;
   pesc_addr_t i_addr = 12'h000;
   pesc_word_t i_wdata = 32'h00000000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   pesc_word_t i_unc_evt = 32'h00000000;
   pesc_word_t i_cor_evt = 32'h00000000;
   pesc_word_t o_rdata, n_cor, n_nf, n_fat, n_log, d;
   pesc_word_t e_cor = 32'h0, e_nf = 32'h0, e_fat = 32'h0, e_log = 32'h0;
   logic o_msg_cor, o_msg_nonfatal, o_msg_fatal, o_log_req, o_irq;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   pesc_row_s rows [6];

   always #4 i_mclk = ~i_mclk;

   pesc_top pesc_top_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_hot_rst(i_hot_rst), .i_port_dsp(i_port_dsp),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_unc_evt(i_unc_evt), .i_cor_evt(i_cor_evt), .o_msg_cor(o_msg_cor),
      .o_msg_nonfatal(o_msg_nonfatal), .o_msg_fatal(o_msg_fatal), .o_log_req(o_log_req), .o_irq(o_irq));

   pesc_rc_model pesc_rc_model_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_msg_cor(o_msg_cor),
      .i_msg_nonfatal(o_msg_nonfatal), .i_msg_fatal(o_msg_fatal), .i_log_req(o_log_req),
      .o_n_cor(n_cor), .o_n_nf(n_nf), .o_n_fat(n_fat), .o_n_log(n_log));

   // ==========================================================
   // tasks
   task automatic chk(input pesc_word_t seen, input pesc_word_t exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input pesc_addr_t a, input pesc_word_t w);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= w;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input pesc_addr_t a);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   task automatic rchk(input pesc_addr_t a, input pesc_word_t exp);
      rd(a);
      chk(d, exp);
   endtask : rchk

   task automatic ev(input pesc_word_t c, input pesc_word_t u);
      @(posedge i_mclk);
      i_cor_evt <= c;
      i_unc_evt <= u;
      @(posedge i_mclk);
      i_cor_evt <= WORD_ZERO;
      i_unc_evt <= WORD_ZERO;
      repeat (3) @(posedge i_mclk);
   endtask : ev

   task automatic cnts;
      chk(n_cor, e_cor);
      chk(n_nf, e_nf);
      chk(n_fat, e_fat);
      chk(n_log, e_log);
   endtask : cnts

   task automatic irq_is(input logic v);
      repeat (2) @(posedge i_mclk);
      #1 chk({31'h0, o_irq}, {31'h0, v});
   endtask : irq_is

   task automatic complete_run;
      if (mismatches == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         complete_run();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      rows = '{'{32'h00000001, 1'b1}, '{32'h00000040, 1'b1}, '{32'h00000080, 1'b1},
               '{32'h00000100, 1'b1}, '{32'h00001000, 1'b1}, '{32'h00002000, 1'b0}};
      repeat (12) @(posedge i_mclk);
      i_srst <= 1'b0;
      rd(UNC_SEV_OFS);
      chk(d & 32'h003E0020, 32'h00060020);
      rchk(COR_STAT_OFS, WORD_ZERO);
      rchk(12'h000, WORD_ZERO);
      foreach (rows[k]) begin
         ev(rows[k].evt, WORD_ZERO);
         e_cor = e_cor + {31'h0, rows[k].msg};
         cnts();
         rchk(COR_STAT_OFS, rows[k].evt);
         wr(COR_STAT_OFS, rows[k].evt);
         rchk(COR_STAT_OFS, WORD_ZERO);
      end
      irq_is(1'b1);
      wr(INT_MASK_OFS, 32'h00000001);
      irq_is(1'b0);
      wr(INT_MASK_OFS, WORD_ZERO);
      irq_is(1'b1);
      wr(INT_STAT_OFS, 32'h00000001);
      irq_is(1'b0);
      // reserved status bits and sticky bit across hot reset
      ev(32'hFFFFFFFF, WORD_ZERO);
      e_cor = e_cor + 32'h1;
      rchk(COR_STAT_OFS, 32'h000031C1);
      wr(COR_STAT_OFS, 32'hFFFFFFFE);
      rchk(INT_STAT_OFS, 32'h00000001);
      @(posedge i_mclk);
      i_hot_rst <= 1'b1;
      @(posedge i_mclk);
      i_hot_rst <= 1'b0;
      rchk(COR_STAT_OFS, 32'h00000001);
      rchk(UNC_SEV_OFS, UNC_SEV_RST);
      rchk(INT_STAT_OFS, WORD_ZERO);
      irq_is(1'b0);
      wr(COR_STAT_OFS, 32'h00000001);
      rchk(COR_STAT_OFS, WORD_ZERO);
      // surprise down dropped upstream, fatal downstream
      ev(WORD_ZERO, 32'h00000020);
      cnts();
      i_port_dsp <= 1'b1;
      repeat (6) @(posedge i_mclk);
      ev(WORD_ZERO, 32'h00000020);
      e_fat++;
      e_log++;
      cnts();
      wr(UNC_SEV_OFS, 32'hFFFFFFFF);
      rchk(UNC_SEV_OFS, 32'h003FF031);
      // write then read with no gap between the strobes
      @(posedge i_mclk);
      i_addr <= UNC_SEV_OFS;
      i_wdata <= 32'hF02AA031;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, 32'h002AA031);
      ev(WORD_ZERO, 32'h00020000);
      e_fat++;
      e_log++;
      cnts();
      wr(UNC_SEV_OFS, WORD_ZERO);
      ev(WORD_ZERO, 32'h00020000);
      e_nf++;
      e_log++;
      cnts();
      wr(UNC_MASK_OFS, 32'h00020000);
      ev(WORD_ZERO, 32'h00020000);
      cnts();
      complete_run();
   end
endmodule : pesc_top_test
`default_nettype wire
